// ---- logic/sfp_link.sv ----
// Serial clock side of the flash front end: shift in, shift out
`timescale 1ns/100ps
module sfp_link (
  input  wire logic             i_sclk,
  input  wire logic             i_rst,
  input  wire logic             i_cs_n,
  input  wire logic [3:0]       i_dq_in,
  input  sfp_pkg::sfp_proto_t   i_proto,
  input  sfp_pkg::sfp_rd_regs_t i_rd_regs,
  output sfp_pkg::sfp_frame_t   o_frame,
  output logic                  o_frame_tog,
  output logic [3:0]            o_dq_out,
  output logic [3:0]            o_dq_oe_n
);
  import sfp_pkg::*;
  sfp_proto_t   proto_s1_q, proto_q;
  sfp_rd_regs_t regs_s1_q, regs_q;
  logic [7:0]   sr_q;
  logic [3:0]   bit_cnt_q;
  logic [2:0]   byte_idx_q;
  logic [15:0]  rd_sr_q;
  logic         rd_act_q;
  wire          is_quad = proto_q == SFP_QUAD;
  wire          is_dual = proto_q == SFP_DUAL;
  wire [3:0]    step = is_quad ? 4'h4 : (is_dual ? 4'h2 : 4'h1);
  wire [7:0]    sr_d = is_quad ? {sr_q[3:0], i_dq_in} :
                       (is_dual ? {sr_q[5:0], i_dq_in[1:0]} : {sr_q[6:0], i_dq_in[0]});
  wire [3:0]    cnt_d = bit_cnt_q + step;
  wire          byte_done = cnt_d == 4'(BYTE_BITS);
  wire          first_byte = byte_idx_q == 3'h0;
  wire [15:0]   rd_sr_shift = is_quad ? {rd_sr_q[11:0], 4'h0} :
                              (is_dual ? {rd_sr_q[13:0], 2'h0} : {rd_sr_q[14:0], 1'h0});

  function automatic logic [16:0] rd_word(input logic [7:0] op, input sfp_rd_regs_t r);
    logic [16:0] w;
    w = '0;
    case (op)
      OP_RDSR: w = {1'h1, r.status, 8'h00};
      OP_RDNV: w = {1'h1, r.nvcr[7:0], r.nvcr[15:8]};
      OP_RDVC: w = {1'h1, r.vcr, 8'h00};
      OP_RDEV: w = {1'h1, r.evcr, 8'h00};
      default: w = '0;
    endcase
    return w;
  endfunction

  wire [16:0] rd_sel = rd_word(sr_d, regs_q);

  // Mode and register values passed through two serial clock stages on every rising edge
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      proto_s1_q <= SFP_EXT;
      proto_q    <= SFP_EXT;
      regs_s1_q  <= '0;
      regs_q     <= '0;
    end else begin
      proto_s1_q <= i_proto;
      proto_q    <= proto_s1_q;
      regs_s1_q  <= i_rd_regs;
      regs_q     <= regs_s1_q;
    end
  end

  always_ff @(posedge i_sclk or posedge i_rst or posedge i_cs_n) begin
    if (i_rst || i_cs_n) begin
      sr_q       <= '0;
      bit_cnt_q  <= '0;
      byte_idx_q <= '0;
      rd_sr_q    <= '0;
      rd_act_q   <= 1'b0;
    end else begin
      sr_q      <= sr_d;
      bit_cnt_q <= byte_done ? 4'h0 : cnt_d;
      if (byte_done && byte_idx_q != 3'h7) begin
        byte_idx_q <= byte_idx_q + 3'h1;
      end
      if (byte_done && first_byte) begin
        rd_sr_q  <= rd_sel[15:0];
        rd_act_q <= rd_sel[16];
      end else if (rd_act_q) begin
        rd_sr_q <= rd_sr_shift;
      end
    end
  end

  // opcode then data captured per frame
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      o_frame     <= '0;
      o_frame_tog <= 1'b0;
    end else if (byte_done && first_byte) begin
      o_frame.opcode <= sr_d;
      o_frame.nbytes <= 3'h1;
      o_frame_tog    <= ~o_frame_tog;
    end else if (byte_done && byte_idx_q <= 3'(LINK_DATA)) begin
      o_frame.data[2'(byte_idx_q - 3'h1)] <= sr_d;
      o_frame.nbytes                      <= byte_idx_q + 3'h1;
    end
  end

  always_ff @(negedge i_sclk or posedge i_rst or posedge i_cs_n) begin
    if (i_rst || i_cs_n) begin
      o_dq_out  <= '0;
      o_dq_oe_n <= 4'hF;
    end else if (rd_act_q) begin
      o_dq_out  <= is_quad ? rd_sr_q[15:12] : (is_dual ? {2'h0, rd_sr_q[15:14]} : {2'h0, rd_sr_q[15], 1'h0});
      o_dq_oe_n <= is_quad ? 4'h0 : (is_dual ? 4'hC : 4'hD);
    end
  end
endmodule

// ---- logic/sfp_pkg.sv ----
// Shared types and constants for the serial flash protocol and status block
package sfp_pkg;
  typedef enum logic [1:0] {SFP_EXT = 2'h0, SFP_DUAL = 2'h1, SFP_QUAD = 2'h2} sfp_proto_t;
  typedef enum logic [2:0] {ST_BOOT = 3'h1, ST_IDLE = 3'h2, ST_BUSY = 3'h4} sfp_state_t;
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LSB = 2;
  localparam int SR_TB = 5;
  localparam int SR_BP_MSB = 6;
  localparam int SR_SRWD = 7;
  localparam int NV_DUAL_N = 2;
  localparam int NV_QUAD_N = 3;
  localparam int NV_XIP_LSB = 9;
  localparam int NV_DUMMY_LSB = 12;
  localparam int EV_DUAL_N = 6;
  localparam int EV_QUAD_N = 7;
  localparam int VCR_XIP = 3;
  localparam int VCR_DUMMY_LSB = 4;
  localparam int BYTE_BITS = 8;
  localparam int LINK_DATA = 3;
  localparam logic [15:0] NVCR_FACTORY = 16'hFFFF;
  localparam logic [5:0] SR_FACTORY = 6'h00;
  localparam logic [2:0] VCR_LOW_RESET = 3'h3;
  localparam logic [5:0] EVCR_LOW_RESET = 6'h3F;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_RDNV = 8'hB5;
  localparam logic [7:0] OP_WRNV = 8'hB1;
  localparam logic [7:0] OP_RDVC = 8'h85;
  localparam logic [7:0] OP_WRVC = 8'h81;
  localparam logic [7:0] OP_RDEV = 8'h65;
  localparam logic [7:0] OP_WREV = 8'h61;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SERASE = 8'hD8;
  localparam logic [7:0] OP_BERASE = 8'hC7;
  localparam logic [7:0] OP_RESCUE = 8'hFF;
  typedef struct packed {logic [7:0] status; logic [15:0] nvcr; logic [7:0] vcr; logic [7:0] evcr;} sfp_rd_regs_t;
  typedef struct packed {logic [7:0] opcode; logic [LINK_DATA-1:0][7:0] data; logic [2:0] nbytes;} sfp_frame_t;
  typedef struct packed {sfp_proto_t proto; logic [3:0] dummy; logic xip_n;} sfp_wcfg_t;
  typedef enum logic [1:0] {ARR_PROG = 2'h0, ARR_SECT = 2'h1, ARR_BULK = 2'h2} sfp_arr_kind_t;
  typedef struct packed {sfp_arr_kind_t kind; logic [23:0] addr;} sfp_arr_cmd_t;
endpackage

// ---- logic/sfp_status_core.sv ----
// Status, protection and protocol selection core of the serial flash front end
`timescale 1ns/100ps
// Summary of operation
// - Factory default protocol is extended, opcode single line
// - Volatile bit7=1 bit6=0 selects dual at once
// - Volatile bit7=0 selects quad at once
// - Volatile choice reverts on reset, rescue, rewrite
// - Nonvolatile bit2 low boots dual
// - Nonvolatile bit3 low boots quad
// - Boot loads working config from nonvolatile
// - Volatile writes update working config immediately
// - Write-disable with protect pin low blocks status writes
// - Bit5 anchors protected area top or bottom
// - Block protect bits shield region
// - Bulk erase only with all protect bits zero
// - Write latch clear at power up, gates status, nonvolatile and array writes
// - Busy bit high during modifying operations
// - Volatile status bits cleared by reset
// - Sample rising edge, drive falling edge
// - Both boot bits low gives quad priority
module sfp_status_core #(
  parameter int unsigned BUSY_CYCLES = 64,
  parameter int unsigned SECTOR_BITS = 7,
  parameter int unsigned SECTOR_LSB  = 16
) (
  input  wire logic           i_core_clk,
  input  wire logic           i_rst,
  input  wire logic           i_sclk,
  input  wire logic           i_cs_n,
  input  wire logic [3:0]     i_dq_in,
  input  wire logic           i_wp_n,
  input  wire logic           i_nv_erase,
  output logic [3:0]          o_dq_out,
  output logic [3:0]          o_dq_oe_n,
  output sfp_pkg::sfp_wcfg_t  o_wcfg,
  output logic [7:0]          o_status,
  output logic                o_array_go,
  output sfp_pkg::sfp_arr_cmd_t o_array_cmd,
  output logic                o_prot_any,
  output logic [SECTOR_BITS-1:0] o_prot_lo,
  output logic [SECTOR_BITS-1:0] o_prot_hi
);
  import sfp_pkg::*;

  localparam int unsigned CNT_W = $clog2(BUSY_CYCLES + 1);
  localparam int unsigned NS_W  = SECTOR_BITS + 1;
  localparam logic [NS_W-1:0] TOTAL_SECT = NS_W'(1) << SECTOR_BITS;
  localparam logic [CNT_W-1:0] BUSY_LOAD = CNT_W'(BUSY_CYCLES - 1);

  // Crossing and pin synchronisers
  logic            cs_s1_q, cs_s2_q, cs_s3_q;
  logic            tog_s1_q, tog_s2_q, tog_s3_q;
  logic            wp_s1_q, wp_s2_q;
  logic            pend_q;

  // Core state
  sfp_state_t      state_q, state_d;
  logic [CNT_W-1:0] busy_cnt_q;
  logic [7:0]      sr_nv_q;
  logic [15:0]     nvcr_q;
  logic [7:0]      vcr_q;
  logic [7:0]      evcr_q;
  logic            wel_q, wel_d;
  sfp_wcfg_t       wcfg_q;
  sfp_rd_regs_t    rd_regs_q;

  // Link side connections
  sfp_frame_t      frame;
  logic            frame_tog;
  logic [3:0]      dq_out;
  logic [3:0]      dq_oe_n;

  sfp_link u_link (
    .i_sclk      (i_sclk),
    .i_rst       (i_rst),
    .i_cs_n      (i_cs_n),
    .i_dq_in     (i_dq_in),
    .i_proto     (wcfg_q.proto),
    .i_rd_regs   (rd_regs_q),
    .o_frame     (frame),
    .o_frame_tog (frame_tog),
    .o_dq_out    (dq_out),
    .o_dq_oe_n   (dq_oe_n)
  );

  assign o_dq_out  = dq_out;
  assign o_dq_oe_n = dq_oe_n;

  function automatic sfp_proto_t proto_sel(input logic quad_n, input logic dual_n);
    sfp_proto_t p;
    p = SFP_EXT;
    if (!quad_n) begin
      p = SFP_QUAD;
    end else if (!dual_n) begin
      p = SFP_DUAL;
    end
    return p;
  endfunction

  function automatic logic [NS_W-1:0] prot_count(input logic [3:0] bp);
    logic [NS_W-1:0] n;
    n = '0;
    if (bp[3]) begin
      n = TOTAL_SECT;
    end else if (bp != 4'h0) begin
      n = NS_W'(1) << (bp[2:0] - 3'h1);
    end
    return n;
  endfunction

  // Frame end and command qualification
  wire             tog_edge  = tog_s2_q ^ tog_s3_q;
  wire             frame_end = cs_s2_q & ~cs_s3_q;
  wire             exec      = frame_end & (pend_q | tog_edge);
  wire             idle      = state_q == ST_IDLE;
  wire             busy      = state_q == ST_BUSY;
  wire             busy_done = busy && busy_cnt_q == '0;
  wire [7:0]       op        = frame.opcode;
  wire [2:0]       nb        = frame.nbytes;
  wire [23:0]      addr      = {frame.data[0], frame.data[1], frame.data[2]};

  wire [3:0]       bp        = {sr_nv_q[SR_BP_MSB], sr_nv_q[SR_BP_LSB +: 3]};
  wire [NS_W-1:0]  prot_n    = prot_count(bp);
  wire [NS_W-1:0]  sector    = NS_W'(addr[SECTOR_LSB +: SECTOR_BITS]);
  wire             tb_bottom = sr_nv_q[SR_TB];
  wire [NS_W-1:0]  lo_d      = tb_bottom ? '0 : TOTAL_SECT - prot_n;
  wire [NS_W-1:0]  hi_d      = tb_bottom ? prot_n - NS_W'(1) : TOTAL_SECT - NS_W'(1);
  wire             sect_prot = prot_n != '0 && sector >= lo_d && sector <= hi_d;

  wire             wp_lock   = sr_nv_q[SR_SRWD] & ~wp_s2_q;

  wire             cmd_ok    = exec & idle;
  wire             do_wren   = cmd_ok && op == OP_WREN;
  wire             do_wrdi   = cmd_ok && op == OP_WRDI;
  wire             do_wrsr   = cmd_ok && wel_q && !wp_lock && op == OP_WRSR && nb >= 3'h2;
  wire             do_wrnv   = cmd_ok && wel_q && op == OP_WRNV && nb >= 3'h3;
  wire             do_wrvc   = cmd_ok && op == OP_WRVC && nb >= 3'h2;
  wire             do_wrev   = cmd_ok && op == OP_WREV && nb >= 3'h2;
  wire             do_rescue = cmd_ok && op == OP_RESCUE;
  wire             do_prog   = cmd_ok && wel_q && !sect_prot && op == OP_PROG && nb >= 3'h4;
  wire             do_sect   = cmd_ok && wel_q && !sect_prot && op == OP_SERASE && nb >= 3'h4;
  // bulk erase needs all protect bits clear
  wire             do_bulk   = cmd_ok && wel_q && bp == 4'h0 && op == OP_BERASE;
  wire             do_array  = do_prog | do_sect | do_bulk;
  wire             start_op  = do_wrsr | do_wrnv | do_array;

  wire [7:0]       ev_new    = frame.data[0];
  wire [15:0]      nv_new    = {frame.data[1], frame.data[0]};
  wire [7:0]       vc_new    = frame.data[0];

  // Synchronisers for the chip select, the frame toggle and the protect pin
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
    end else begin
      cs_s1_q  <= i_cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      tog_s1_q <= frame_tog;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      wp_s1_q  <= i_wp_n;
      wp_s2_q  <= wp_s1_q;
    end
  end

  // Frame arrival held until chip select rises, a rise in the same cycle clears it
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= 1'b0;
    end else if (tog_edge) begin
      pend_q <= ~frame_end;
    end else if (frame_end) begin
      pend_q <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_BOOT: begin
        state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (start_op) begin
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (busy_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
  end

  // end of operation clears latch with busy
  always_comb begin
    wel_d = wel_q;
    if (busy_done) begin
      wel_d = 1'b0;
    end else if (do_wren) begin
      wel_d = 1'b1;
    end else if (do_wrdi) begin
      wel_d = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q    <= ST_BOOT;
      wel_q      <= 1'b0;
      busy_cnt_q <= '0;
    end else begin
      state_q    <= state_d;
      wel_q      <= wel_d;
      if (start_op) begin
        busy_cnt_q <= BUSY_LOAD;
      end else if (busy && busy_cnt_q != '0) begin
        busy_cnt_q <= busy_cnt_q - CNT_W'(1);
      end
    end
  end

  // Nonvolatile cells survive reset, written only by commands or erase
  always_ff @(posedge i_core_clk) begin
    if (i_nv_erase) begin
      nvcr_q  <= NVCR_FACTORY;
      sr_nv_q <= {SR_FACTORY, 2'h0};
    end else begin
      if (do_wrsr) begin
        sr_nv_q <= {frame.data[0][SR_SRWD:SR_BP_LSB], 2'h0};
      end
      if (do_wrnv) begin
        nvcr_q <= nv_new;
      end
    end
  end

  // Volatile configuration and working configuration
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      vcr_q  <= '0;
      evcr_q <= '0;
      wcfg_q <= '{proto: SFP_EXT, dummy: 4'h0, xip_n: 1'b1};
    end else if (state_q == ST_BOOT) begin
      // quad wins when both bits low
      wcfg_q.proto <= proto_sel(nvcr_q[NV_QUAD_N], nvcr_q[NV_DUAL_N]);
      wcfg_q.dummy <= nvcr_q[NV_DUMMY_LSB +: 4];
      wcfg_q.xip_n <= &nvcr_q[NV_XIP_LSB +: 3];
      vcr_q        <= {nvcr_q[NV_DUMMY_LSB +: 4], &nvcr_q[NV_XIP_LSB +: 3], VCR_LOW_RESET};
      evcr_q       <= {nvcr_q[NV_QUAD_N], nvcr_q[NV_DUAL_N], EVCR_LOW_RESET};
    end else begin
      if (do_wrvc) begin
        vcr_q        <= vc_new;
        wcfg_q.dummy <= vc_new[VCR_DUMMY_LSB +: 4];
        wcfg_q.xip_n <= vc_new[VCR_XIP];
      end
      if (do_wrev) begin
        evcr_q       <= ev_new;
        wcfg_q.proto <= proto_sel(ev_new[EV_QUAD_N], ev_new[EV_DUAL_N]);
      end else if (do_rescue) begin
        evcr_q[EV_QUAD_N] <= 1'b1;
        evcr_q[EV_DUAL_N] <= 1'b1;
        wcfg_q.proto      <= SFP_EXT;
      end
    end
  end

  wire [7:0] status_now = {sr_nv_q[SR_SRWD:SR_BP_LSB], wel_q, busy};

  // Outputs and values offered to the serial side
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status    <= '0;
      o_wcfg      <= '{proto: SFP_EXT, dummy: 4'h0, xip_n: 1'b1};
      o_array_go  <= 1'b0;
      o_array_cmd <= '0;
      o_prot_any  <= 1'b0;
      o_prot_lo   <= '0;
      o_prot_hi   <= '0;
      rd_regs_q   <= '0;
    end else begin
      o_status   <= status_now;
      o_wcfg     <= wcfg_q;
      o_array_go <= do_array;
      if (do_array) begin
        o_array_cmd.kind <= do_bulk ? ARR_BULK : (do_sect ? ARR_SECT : ARR_PROG);
        o_array_cmd.addr <= addr;
      end
      o_prot_any <= prot_n != '0;
      o_prot_lo  <= lo_d[SECTOR_BITS-1:0];
      o_prot_hi  <= hi_d[SECTOR_BITS-1:0];
      // values returned by the read commands
      rd_regs_q  <= '{status: status_now, nvcr: nvcr_q, vcr: vcr_q, evcr: evcr_q};
    end
  end
endmodule

// ---- tb/sfp_host.sv ----
// Serial bus host model framing flash commands
`timescale 1ns/100ps
module sfp_host (
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic [3:0]      o_dq,
  input  wire logic [3:0] i_dq
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq   = 4'h5;
  end
  // drive on fall, sample on rise
  task automatic xfer(input int w, input logic [31:0] sh, input int n, input int nr, output logic [15:0] rd);
    rd     = 16'h0;
    o_cs_n = 1'b0;
    for (int i = 0; i < n + nr; i += w) begin
      for (int j = 0; j < 4; j++) begin
        o_dq[j] = (i < n && j < w) ? sh[32 - w + j] : ~o_dq[j];
      end
      sh = sh << w;
      #7.5;
      o_sclk = 1'b1;
      if (i >= n) begin
        rd = rd << w;
        for (int j = 0; j < w; j++) begin
          rd[j] = i_dq[(w == 1) ? 1 : j];
        end
      end
      #7.5;
      o_sclk = 1'b0;
    end
    #7.5;
    o_cs_n = 1'b1;
    o_dq   = ~o_dq;
  endtask
endmodule

// ---- tb/sfp_status_core_props.sv ----
// Port checks for the flash status and protocol core
`timescale 1ns/100ps
module sfp_status_core_props #(
  parameter int unsigned BUSY_CYCLES = 64,
  parameter int unsigned SECTOR_BITS = 7
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_cs_n,
  input  wire logic                   i_wp_n,
  input  wire logic                   i_nv_erase,
  input  wire logic [3:0]             o_dq_oe_n,
  input  wire logic [7:0]             o_status,
  input  wire logic                   o_array_go,
  input  sfp_pkg::sfp_arr_cmd_t       o_array_cmd,
  input  wire logic                   o_prot_any,
  input  wire logic [SECTOR_BITS-1:0] o_prot_lo,
  input  wire logic [SECTOR_BITS-1:0] o_prot_hi
);
  import sfp_pkg::*;
  logic [3:0]  wp_lo_q;
  int unsigned busy_n_q;
  // Pin low history and busy length
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_lo_q  <= 4'h0;
      busy_n_q <= 0;
    end else begin
      wp_lo_q  <= {wp_lo_q[2:0], ~i_wp_n};
      busy_n_q <= o_status[SR_WIP] ? busy_n_q + 1 : 0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_settled;
    $stable(o_status) [*3];
  endsequence
  sequence s_done;
    $fell(o_status[SR_WIP]);
  endsequence
  a_reset_vol_clear: assert property ($fell(i_rst) |-> o_status[1:0] == 2'h0)
    else $error("volatile status set after reset");
  a_done_drops_wel: assert property (s_done |-> $fell(o_status[SR_WEL]))
    else $error("busy and latch did not clear together");
  a_busy_needs_wel: assert property ($rose(o_status[SR_WIP]) |-> $past(o_status[SR_WEL]))
    else $error("busy without write latch");
  a_busy_length: assert property (s_done |-> busy_n_q >= BUSY_CYCLES && busy_n_q <= BUSY_CYCLES + 1)
    else $error("busy length wrong");
  a_go_needs_wel: assert property (o_array_go |-> $past(o_status[SR_WEL]) && !$past(o_status[SR_WIP]))
    else $error("array command without latch or while busy");
  a_bulk_unprot: assert property (o_array_go && o_array_cmd.kind == ARR_BULK |-> {o_status[SR_BP_MSB], o_status[4:2]} == 4'h0)
    else $error("bulk erase while protected");
  a_prot_any_bp: assert property (s_settled |-> o_prot_any == (o_status[SR_BP_MSB] | (|o_status[4:2])))
    else $error("protection flag disagrees with protect bits");
  a_prot_anchor: assert property (s_settled ##0 o_prot_any |-> (o_status[SR_TB] ? o_prot_lo == '0 : o_prot_hi == '1))
    else $error("protected range anchored wrongly");
  a_wp_locks_nv: assert property (&wp_lo_q && $past(o_status[SR_SRWD]) && !i_nv_erase |-> $stable(o_status[7:2]))
    else $error("locked status bits changed");
  a_oe_idle_cs: assert property (i_cs_n |-> o_dq_oe_n == 4'hF)
    else $error("data lines driven while deselected");
endmodule
bind sfp_status_core sfp_status_core_props #(.BUSY_CYCLES(BUSY_CYCLES), .SECTOR_BITS(SECTOR_BITS)) u_props (.*);

// ---- tb/sfp_status_core_tb.sv ----
// Self-checking bench for the flash status and protocol core
`timescale 1ns/100ps
module sfp_status_core_tb;
  import sfp_pkg::*;
  localparam logic [7:0] EV_VAL [3] = '{8'hBF, 8'h7F, 8'hFF};
  localparam sfp_proto_t EV_PRO [3] = '{SFP_DUAL, SFP_QUAD, SFP_EXT};
  localparam logic [7:0] NV_LO [4] = '{8'hFB, 8'hF3, 8'hF7, 8'hFF};
  localparam sfp_proto_t NV_PRO [4] = '{SFP_DUAL, SFP_QUAD, SFP_QUAD, SFP_EXT};
  logic         clk = 1'b0;
  logic         rst = 1'b0;
  logic         wp_n = 1'b1;
  logic         nv_erase = 1'b1;
  logic         sclk;
  logic         cs_n;
  logic [3:0]   host_dq;
  logic [3:0]   dq_out;
  logic [3:0]   oe_n;
  logic [3:0]   dq_w;
  sfp_wcfg_t    wcfg;
  logic [7:0]   status;
  logic         go;
  sfp_arr_cmd_t acmd;
  sfp_arr_cmd_t last_cmd;
  logic         prot_any;
  logic [6:0]   plo;
  logic [6:0]   phi;
  logic [15:0]  rd;
  int           err_count = 0;
  int           comparisons = 0;
  int           go_n = 0;
  int           w = 1;
  always #4 clk = ~clk;
  assign dq_w = (oe_n & host_dq) | (~oe_n & dq_out);
  always @(negedge clk) if (go) begin
    go_n++;
    last_cmd = acmd;
  end
  sfp_status_core #(.BUSY_CYCLES(16)) DUT (
    .i_core_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_dq_in(dq_w), .i_wp_n(wp_n),
    .i_nv_erase(nv_erase), .o_dq_out(dq_out), .o_dq_oe_n(oe_n), .o_wcfg(wcfg), .o_status(status),
    .o_array_go(go), .o_array_cmd(acmd), .o_prot_any(prot_any), .o_prot_lo(plo), .o_prot_hi(phi)
  );
  sfp_host HOST (.o_sclk(sclk), .o_cs_n(cs_n), .o_dq(host_dq), .i_dq(dq_w));
  function automatic int lanes(sfp_proto_t p);
    return (p == SFP_QUAD) ? 4 : (p == SFP_DUAL) ? 2 : 1;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input int nb, input logic [23:0] d, input int nr);
    HOST.xfer(w, {op, d}, 8 + 8 * nb, nr, rd);
    repeat (8) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] op, input int nb, input logic [23:0] d);
    cmd(OP_WREN, 0, 24'h0, 0);
    cmd(op, nb, d, 0);
  endtask
  task automatic idle();
    for (int i = 0; i < 200 && status[SR_WIP] !== 1'b0; i++) @(negedge clk);
  endtask
  task automatic sync_link();
    HOST.xfer(w, 32'h0, 2 * w, 0, rd);
    repeat (8) @(negedge clk);
  endtask
  task automatic reboot();
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
  initial begin
    #1 rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    nv_erase = 1'b0;
    repeat (8) @(negedge clk);
    sync_link();
    chk("proto", 32'(wcfg.proto), 32'(SFP_EXT));
    chk("status", 32'(status), 32'h0);
    cmd(OP_WRSR, 1, 24'h1C0000, 0);
    chk("status", 32'(status), 32'h0);
    cmd(OP_WREN, 0, 24'h0, 0);
    chk("wel", 32'(status), 32'h2);
    cmd(OP_WRDI, 0, 24'h0, 0);
    chk("wel", 32'(status), 32'h0);
    cmd(OP_WRVC, 1, 24'h530000, 0);
    chk("vcfg", 32'(wcfg), 32'({SFP_EXT, 4'h5, 1'b0}));
    cmd(OP_RDVC, 0, 24'h0, 8);
    chk("rdvc", 32'(rd), 32'h53);
    wr(OP_WRSR, 1, 24'h0C0000);
    chk("busy", 32'(status[1:0]), 32'h3);
    idle();
    chk("status", 32'(status), 32'h0C);
    cmd(OP_RDSR, 0, 24'h0, 8);
    chk("rdsr", 32'(rd), 32'h0C);
    chk("plo", 32'(plo), 32'h7C);
    chk("phi", 32'(phi), 32'h7F);
    chk("pany", 32'(prot_any), 32'h1);
    wr(OP_SERASE, 3, 24'h7F0000);
    wr(OP_BERASE, 0, 24'h0);
    wr(OP_PROG, 4, 24'h7E0000);
    chk("go", 32'(go_n), 32'h0);
    wr(OP_SERASE, 3, 24'h010000);
    idle();
    chk("arr", 32'(last_cmd), 32'({ARR_SECT, 24'h010000}));
    wr(OP_WRSR, 1, 24'h2C0000);
    idle();
    chk("prange", 32'({plo, phi}), 32'h0003);
    wr(OP_PROG, 4, 24'h020000);
    wr(OP_PROG, 4, 24'h050000);
    idle();
    chk("prog", 32'(last_cmd), 32'({ARR_PROG, 24'h050000}));
    wr(OP_WRSR, 1, 24'h0);
    idle();
    wr(OP_BERASE, 0, 24'h0);
    idle();
    chk("bulk", 32'({go_n[7:0], 6'h0, last_cmd.kind}), 32'({8'h3, 6'h0, ARR_BULK}));
    wr(OP_WRSR, 1, 24'h800000);
    idle();
    wp_n = 1'b0;
    wr(OP_WRSR, 1, 24'h1C0000);
    chk("locked", 32'(status[7:2]), 32'h20);
    wp_n = 1'b1;
    repeat (4) @(negedge clk);
    wr(OP_WRSR, 1, 24'h0);
    idle();
    chk("unlocked", 32'(status), 32'h0);
    for (int k = 0; k < 3; k++) begin
      cmd(OP_WREV, 1, {EV_VAL[k], 16'h0}, 0);
      chk("proto", 32'(wcfg.proto), 32'(EV_PRO[k]));
      w = lanes(EV_PRO[k]);
      sync_link();
      cmd(OP_RDEV, 0, 24'h0, 8);
      chk("rdev", 32'(rd), 32'(EV_VAL[k]));
    end
    cmd(OP_WREV, 1, 24'h7F0000, 0);
    w = 4;
    sync_link();
    cmd(OP_RESCUE, 0, 24'h0, 0);
    chk("rescue", 32'(wcfg.proto), 32'(SFP_EXT));
    w = 1;
    sync_link();
    cmd(OP_WREV, 1, 24'hBF0000, 0);
    reboot();
    chk("revert", 32'(wcfg.proto), 32'(SFP_EXT));
    sync_link();
    for (int k = 0; k < 4; k++) begin
      wr(OP_WRNV, 2, {NV_LO[k], 16'hFF00});
      idle();
      reboot();
      chk("boot", 32'(wcfg), 32'({NV_PRO[k], 4'hF, 1'b1}));
      w = lanes(NV_PRO[k]);
      sync_link();
      cmd(OP_RDNV, 0, 24'h0, 16);
      chk("rdnv", 32'(rd), 32'({NV_LO[k], 8'hFF}));
    end
    end_sim();
  end
endmodule
